/* src/inrap_pkg.sv */
package inrap_pkg;

    // ==========================================
    // bus geometry
    localparam int INRAP_ADDR_W = 5;
    localparam int INRAP_DATA_W = 8;
    localparam int INRAP_PTR_W = 8;
    localparam int INRAP_RAM_DEPTH = 256;

    // ==========================================
    // register map
    localparam logic [INRAP_ADDR_W-1:0] INRAP_OFS_POINTER = 5'h10;
    localparam logic [INRAP_ADDR_W-1:0] INRAP_OFS_DATA_WINDOW = 5'h13;

    // ==========================================
    // reset values and constants
    localparam logic [INRAP_PTR_W-1:0] INRAP_PTR_RESET = 8'h00;
    localparam logic [INRAP_PTR_W-1:0] INRAP_PTR_STEP = 8'h01;
    localparam logic [INRAP_PTR_W-1:0] INRAP_PTR_LAST = 8'hff;
    localparam logic [INRAP_PTR_W-1:0] INRAP_PTR_FIRST = 8'h00;
    localparam logic [INRAP_DATA_W-1:0] INRAP_DATA_RESET = 8'h00;
    localparam logic [INRAP_ADDR_W-1:0] INRAP_ADDR_RESET = 5'h00;

    // ==========================================
    // access phase
    typedef enum logic [1:0]
    {
        INRAP_IDLE = 2'b01,
        INRAP_ACTIVE = 2'b10
    } inrap_phase_t;

endpackage

/* src/inrap_ram.sv */
module inrap_ram
#(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 8,
    parameter int DEPTH = 256
)
(
    input wire logic CLOCK_I,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] waddr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic [ADDR_W-1:0] raddr_i,
    output logic [DATA_W-1:0] rdata_o
);

    // ==========================================
    // storage, battery backed so no reset
    logic [DATA_W-1:0] mem [DEPTH];

    always_ff @(posedge CLOCK_I)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
    end

    assign rdata_o = mem[raddr_i];

endmodule

/* src/inrap_top.sv */
module inrap_top
    import inrap_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    input wire logic CE_B_I,
    input wire logic OE_B_I,
    input wire logic WE_B_I,
    input wire logic [inrap_pkg::INRAP_ADDR_W-1:0] ADDR_I,
    input wire logic [inrap_pkg::INRAP_DATA_W-1:0] DATA_I,
    input wire logic BURST_INCREMENT_ENABLE_I,
    output logic [inrap_pkg::INRAP_DATA_W-1:0] DATA_O,
    output logic DATA_OE_O
);

    import inrap_pkg::*;

    // ==========================================
    // helpers
    function automatic logic is_pointer(input logic [INRAP_ADDR_W-1:0] a);
        is_pointer = (a == INRAP_OFS_POINTER);
    endfunction

    function automatic logic is_window(input logic [INRAP_ADDR_W-1:0] a);
        is_window = (a == INRAP_OFS_DATA_WINDOW);
    endfunction

    // ==========================================
    // state
    typedef struct packed
    {
        inrap_phase_t phase;
        logic [INRAP_ADDR_W-1:0] addr;
        logic [INRAP_DATA_W-1:0] wdata;
        logic wr;
        logic [INRAP_PTR_W-1:0] ptr;
        logic [INRAP_DATA_W-1:0] rdata;
    } inrap_state_t;

    localparam inrap_state_t INRAP_STATE_RESET = '{
        phase: INRAP_IDLE,
        addr: INRAP_ADDR_RESET,
        wdata: INRAP_DATA_RESET,
        wr: 1'b0,
        ptr: INRAP_PTR_RESET,
        rdata: INRAP_DATA_RESET
    };

    inrap_state_t s_q;
    inrap_state_t s_d;

    logic rd_now;
    logic wr_now;
    logic act_now;
    logic acc_end;
    logic ram_we;
    logic [INRAP_DATA_W-1:0] ram_rdata;

    // ==========================================
    // strobe decode
    assign rd_now = !CE_B_I && !OE_B_I && WE_B_I;
    assign wr_now = !CE_B_I && !WE_B_I;
    assign act_now = rd_now || wr_now;
    // a rising edge of CE_B_I or of the access's own strobe (OE_B_I on a read, WE_B_I on a write with OE_B_I high) closes the access
    assign acc_end = (s_q.phase == INRAP_ACTIVE) && !act_now;
    assign ram_we = acc_end && s_q.wr && is_window(s_q.addr);

    // ==========================================
    // next state
    always_comb
    begin
        s_d = s_q;
        case (s_q.phase)
            INRAP_IDLE:
            begin
                if (act_now)
                begin
                    s_d.phase = INRAP_ACTIVE;
                end
            end
            INRAP_ACTIVE:
            begin
                if (!act_now)
                begin
                    s_d.phase = INRAP_IDLE;
                end
            end
            default:
            begin
                s_d.phase = INRAP_IDLE;
            end
        endcase
        // track the access while strobes are low; last values are used at release
        if (act_now)
        begin
            s_d.addr = ADDR_I;
            s_d.wr = wr_now;
            if (wr_now)
            begin
                s_d.wdata = DATA_I;
            end
        end
        if (acc_end)
        begin
            if (s_q.wr && is_pointer(s_q.addr))
            begin
                s_d.ptr = s_q.wdata;
            end
            else if (is_window(s_q.addr) && BURST_INCREMENT_ENABLE_I)
            begin
                // 8-bit add rolls over from the last byte to the first
                s_d.ptr = s_q.ptr + INRAP_PTR_STEP;
            end
        end
        if (is_pointer(ADDR_I))
        begin
            s_d.rdata = s_q.ptr;
        end
        else
        begin
            s_d.rdata = ram_rdata;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            s_q <= INRAP_STATE_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // ram
    inrap_ram
    #(
        .DATA_W(INRAP_DATA_W),
        .ADDR_W(INRAP_PTR_W),
        .DEPTH(INRAP_RAM_DEPTH)
    )
    inrap_ram_i
    (
        .CLOCK_I(CLOCK_I),
        .we_i(ram_we),
        .waddr_i(s_q.ptr),
        .wdata_i(s_q.wdata),
        .raddr_i(s_q.ptr),
        .rdata_o(ram_rdata)
    );

    // ==========================================
    // outputs
    assign DATA_O = s_q.rdata;
    assign DATA_OE_O = rd_now && (is_pointer(ADDR_I) || is_window(ADDR_I));

    // ==========================================
    // assertions
    sequence s_window_end;
        acc_end && is_window(s_q.addr);
    endsequence

    sequence s_pointer_write_end;
        acc_end && s_q.wr && is_pointer(s_q.addr);
    endsequence

    a_pointer_load: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        s_pointer_write_end |=> s_q.ptr == $past(s_q.wdata))
        else $error("pointer not loaded from write data");

    a_read_window: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        (rd_now && is_window(ADDR_I)) |=> DATA_O == $past(ram_rdata))
        else $error("window read data wrong");

    a_write_window: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        (s_window_end and s_q.wr) |=> inrap_ram_i.mem[$past(s_q.ptr)] == $past(s_q.wdata))
        else $error("window write not stored at pointer");

    a_write_reads_back: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        (ram_we && !BURST_INCREMENT_ENABLE_I) |=> ram_rdata == $past(s_q.wdata))
        else $error("written byte not stored at pointer");

    a_static_pointer: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        (s_window_end and !BURST_INCREMENT_ENABLE_I) |=> $stable(s_q.ptr))
        else $error("pointer moved without burst");

    a_burst_step: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        (s_window_end and BURST_INCREMENT_ENABLE_I and s_q.ptr != INRAP_PTR_LAST)
        |=> s_q.ptr == $past(s_q.ptr) + INRAP_PTR_STEP)
        else $error("burst did not advance by one");

    a_burst_at_release: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        !acc_end |=> $stable(s_q.ptr))
        else $error("pointer changed outside a strobe release");

    a_burst_wrap: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        (s_window_end and BURST_INCREMENT_ENABLE_I and s_q.ptr == INRAP_PTR_LAST)
        |=> s_q.ptr == INRAP_PTR_FIRST)
        else $error("pointer did not wrap");

    a_other_addr: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        (acc_end && !is_window(s_q.addr) && !(s_q.wr && is_pointer(s_q.addr)))
        |=> $stable(s_q.ptr))
        else $error("pointer changed by another address");

    a_drive_only_read: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        DATA_OE_O |-> (!CE_B_I && !OE_B_I && WE_B_I))
        else $error("data driven outside a read");

endmodule

/* tb/inrap_host.sv */
module inrap_host
    import inrap_pkg::*;
(
    input wire logic clock_i,
    input wire logic [inrap_pkg::INRAP_DATA_W-1:0] data_i,
    input wire logic data_oe_i,
    output logic ce_b_o,
    output logic oe_b_o,
    output logic we_b_o,
    output logic [inrap_pkg::INRAP_ADDR_W-1:0] addr_o,
    output logic [inrap_pkg::INRAP_DATA_W-1:0] data_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import inrap_pkg::*;

    // ==========================================
    // idle bus
    initial
    begin
        ce_b_o = 1'b1;
        oe_b_o = 1'b1;
        we_b_o = 1'b1;
        addr_o = INRAP_ADDR_RESET;
        data_o = INRAP_DATA_RESET;
    end

    // ==========================================
    // one access: strobes low for three edges, then one idle edge
    task automatic access(input logic wr, input logic [INRAP_ADDR_W-1:0] a,
        input logic [INRAP_DATA_W-1:0] d, output logic [INRAP_DATA_W-1:0] q,
        output logic oe);
    begin
        ce_b_o <= 1'b0;
        oe_b_o <= wr;
        we_b_o <= !wr;
        addr_o <= a;
        data_o <= d;
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        q = data_i;
        oe = data_oe_i;
        @(posedge clock_i);
        ce_b_o <= 1'b1;
        oe_b_o <= 1'b1;
        we_b_o <= 1'b1;
        // released data lines must not keep the last value
        data_o <= ~d;
        @(posedge clock_i);
    end
    endtask
endmodule

/* tb/inrap_top_tb.sv */
module inrap_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import inrap_pkg::*;

    logic clk, rst_b, ce_b, oe_b, we_b, burst, doe, oe;
    logic [INRAP_ADDR_W-1:0] addr;
    logic [INRAP_DATA_W-1:0] wdata, rdata, q;
    int n_errors = 0;
    int n_tests = 0;

    inrap_top inrap_top_i (.CLOCK_I(clk), .RST_B_I(rst_b), .CE_B_I(ce_b), .OE_B_I(oe_b),
        .WE_B_I(we_b), .ADDR_I(addr), .DATA_I(wdata), .BURST_INCREMENT_ENABLE_I(burst),
        .DATA_O(rdata), .DATA_OE_O(doe));
    inrap_host inrap_host_i (.clock_i(clk), .data_i(rdata), .data_oe_i(doe), .ce_b_o(ce_b),
        .oe_b_o(oe_b), .we_b_o(we_b), .addr_o(addr), .data_o(wdata));

    // ==========================================
    // clock and watchdog
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("BAD t=%0t timeout", $time);
        tally_and_finish();
    end

    // ==========================================
    // tasks
    task automatic tally_and_finish();
    begin
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask

    task automatic wr(input logic [INRAP_ADDR_W-1:0] a, input logic [INRAP_DATA_W-1:0] d);
        inrap_host_i.access(1'b1, a, d, q, oe);
    endtask

    // data is compared only where the read is expected to be driven
    task automatic rd(input logic [INRAP_ADDR_W-1:0] a, input logic [INRAP_DATA_W-1:0] e,
        input logic eoe);
    begin
        inrap_host_i.access(1'b0, a, INRAP_DATA_RESET, q, oe);
        n_tests++;
        if (oe !== eoe || (eoe && q !== e))
        begin
            n_errors++;
            $display("BAD t=%0t addr %h got %h/%b exp %h/%b", $time, a, q, oe, e, eoe);
        end
    end
    endtask

    // ==========================================
    // sequence
    initial
    begin
        rst_b = 1'b0;
        burst = 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        wr(INRAP_OFS_POINTER, 8'h80);
        rd(INRAP_OFS_POINTER, 8'h80, 1'b1);
        $display("test pointer load done");
        burst <= 1'b1;
        for (int i = 0; i < 256; i++)
            wr(INRAP_OFS_DATA_WINDOW, i[7:0] ^ 8'h5a);
        rd(INRAP_OFS_POINTER, 8'h80, 1'b1);
        wr(INRAP_OFS_POINTER, 8'h80);
        for (int i = 0; i < 256; i++)
            rd(INRAP_OFS_DATA_WINDOW, i[7:0] ^ 8'h5a, 1'b1);
        $display("test burst sweep done");
        burst <= 1'b0;
        wr(INRAP_OFS_POINTER, 8'hfe);
        wr(INRAP_OFS_DATA_WINDOW, 8'hc3);
        rd(INRAP_OFS_DATA_WINDOW, 8'hc3, 1'b1);
        rd(INRAP_OFS_DATA_WINDOW, 8'hc3, 1'b1);
        rd(INRAP_OFS_POINTER, 8'hfe, 1'b1);
        $display("test static pointer done");
        burst <= 1'b1;
        wr(5'h11, 8'h00);
        rd(5'h11, 8'h00, 1'b0);
        rd(INRAP_OFS_POINTER, 8'hfe, 1'b1);
        rd(INRAP_OFS_DATA_WINDOW, 8'hc3, 1'b1);
        rd(INRAP_OFS_POINTER, 8'hff, 1'b1);
        $display("test other addresses done");
        tally_and_finish();
    end
endmodule
